/* rtl/fuse_bank_pkg.sv */
// Constants shared by the configuration fuse bank and its bus port.
// Assumes a 32-bit AXI4-Lite bus and one core clock.
package fuse_bank_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 32;
    localparam int NUM_REGS = 3;

    // Register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] DEBUG_IDX = 24'h30_0006;
    localparam logic [ADDR_W-1:0] PROG_IDX  = 24'h30_0008;
    localparam logic [ADDR_W-1:0] BOOT_IDX  = 24'h30_0009;
    localparam logic [ADDR_W-1:0] DEBUG_ADDR = ADDR_W'(32'(DEBUG_IDX) * 32'd4);
    localparam logic [ADDR_W-1:0] PROG_ADDR  = ADDR_W'(32'(PROG_IDX) * 32'd4);
    localparam logic [ADDR_W-1:0] BOOT_ADDR  = ADDR_W'(32'(BOOT_IDX) * 32'd4);

    // Slot numbers of the three bytes
    localparam int SLOT_DEBUG = 0;
    localparam int SLOT_PROG  = 1;
    localparam int SLOT_BOOT  = 2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DBG_OFF_BIT   = 7;
    localparam int LOWVOLT_BIT   = 2;
    localparam int STACK_RST_BIT = 0;
    localparam int EEPROM_BIT    = 7;
    localparam int BOOT_BIT      = 6;
    localparam int NUM_BLOCKS    = 4;

    // Implemented bits; unprogrammed value equals the mask
    localparam logic [7:0] DEBUG_IMPL = 8'h85;
    localparam logic [7:0] PROG_IMPL  = 8'h0F;
    localparam logic [7:0] SMALL_IMPL = 8'h03;
    localparam logic [7:0] BOOT_IMPL  = 8'hC0;
    // Bits that may only go from one to zero
    localparam logic [7:0] DEBUG_CLR  = 8'h00;
    localparam logic [7:0] PROG_CLR   = 8'h0F;
    localparam logic [7:0] BOOT_CLR   = 8'hC0;

    // ************************************************************
    // Program memory map
    // ************************************************************
    localparam int                PROG_ADDR_W = 21;
    localparam logic [20:0]       BOOT_LAST   = 21'h00_01FF;
    localparam int                BLOCK_SHIFT = 13;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_WRESP = 3'h2,
        ST_RDATA = 3'h4
    } port_state_t;

endpackage

/* rtl/fuse_byte.sv */
// One configuration byte: programmable bits and clear-only bits.
// Assumes the caller qualifies wr_en with a decoded address.
`timescale 1ns/10ps
`default_nettype none
module fuse_byte
#(
    parameter logic [7:0] IMPL_MASK  = 8'hFF,
    parameter logic [7:0] CLEAR_MASK = 8'h00
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value_r
);

    // ************************************************************
    // Update
    // ************************************************************
    wire logic [7:0] prog_mask = IMPL_MASK & ~CLEAR_MASK;
    // Clear-only bits can never be set again by a write
    wire logic [7:0] value_nxt = (wr_data & prog_mask) | (value_r & wr_data & CLEAR_MASK);

    if ((CLEAR_MASK & ~IMPL_MASK) != 8'h00)
    begin : g_bad_mask
        $error("Clear-only bits must be implemented");
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            value_r <= IMPL_MASK;
        else if (wr_en)
            value_r <= value_nxt;
    end

endmodule
`default_nettype wire

/* rtl/fuse_axil_port.sv */
// AXI4-Lite slave handshake for the fuse bank; one transfer at a time.
// Assumes the register file answers reads and writes combinationally.
`timescale 1ns/10ps
`default_nettype none
module fuse_axil_port
(
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [fuse_bank_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                             awvalid,
    output logic                                  awready,
    input  wire logic [31:0]                      wdata,
    input  wire logic [3:0]                       wstrb,
    input  wire logic                             wvalid,
    output logic                                  wready,
    output logic [1:0]                            bresp,
    output logic                                  bvalid,
    input  wire logic                             bready,
    input  wire logic                             arvalid,
    output logic                                  arready,
    output logic [31:0]                           rdata,
    output logic [1:0]                            rresp,
    output logic                                  rvalid,
    input  wire logic                             rready,
    output logic                                  wr_fire,
    output logic [fuse_bank_pkg::ADDR_W-1:0]      wr_addr,
    output logic [31:0]                           wr_data,
    output logic [3:0]                            wr_strb,
    input  wire logic                             wr_ok,
    output logic                                  rd_fire,
    input  wire logic [31:0]                      rd_data,
    input  wire logic                             rd_ok
);

    fuse_bank_pkg::port_state_t state_r;
    fuse_bank_pkg::port_state_t state_nxt;
    logic                       aw_got_r;
    logic                       w_got_r;

    // ************************************************************
    // Handshakes
    // ************************************************************
    wire logic idle = (state_r == fuse_bank_pkg::ST_IDLE);
    assign awready = idle & ~aw_got_r;
    assign wready  = idle & ~w_got_r;
    // Pending write halves take priority over a new read
    assign arready = idle & ~aw_got_r & ~w_got_r;
    assign wr_fire = idle & aw_got_r & w_got_r;
    assign rd_fire = arvalid & arready;
    assign bvalid  = (state_r == fuse_bank_pkg::ST_WRESP);
    assign rvalid  = (state_r == fuse_bank_pkg::ST_RDATA);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            fuse_bank_pkg::ST_IDLE:
                if (wr_fire)
                    state_nxt = fuse_bank_pkg::ST_WRESP;
                else if (rd_fire)
                    state_nxt = fuse_bank_pkg::ST_RDATA;
            fuse_bank_pkg::ST_WRESP:
                if (bready)
                    state_nxt = fuse_bank_pkg::ST_IDLE;
            fuse_bank_pkg::ST_RDATA:
                if (rready)
                    state_nxt = fuse_bank_pkg::ST_IDLE;
            default:
                state_nxt = fuse_bank_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r  <= fuse_bank_pkg::ST_IDLE;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            wr_addr  <= '0;
            wr_data  <= '0;
            wr_strb  <= '0;
            bresp    <= fuse_bank_pkg::RESP_OKAY;
            rresp    <= fuse_bank_pkg::RESP_OKAY;
            rdata    <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            aw_got_r <= (aw_got_r | (awvalid & awready)) & ~wr_fire;
            w_got_r  <= (w_got_r | (wvalid & wready)) & ~wr_fire;
            if (awvalid & awready)
                wr_addr <= awaddr;
            if (wvalid & wready)
            begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_fire)
                bresp <= wr_ok ? fuse_bank_pkg::RESP_OKAY : fuse_bank_pkg::RESP_SLVERR;
            if (rd_fire)
            begin
                rdata <= rd_data;
                rresp <= rd_ok ? fuse_bank_pkg::RESP_OKAY : fuse_bank_pkg::RESP_SLVERR;
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/fuse_protect_bank.sv */
// Configuration fuse bank: debug, programming and protection bytes; the stack reset bit sits in the debug byte.
// Assumes an AXI4-Lite master on aclk and a core that reports stack events.
//
// Overview of operation
// [R01] Debug field one frees both debug pins
// [R02] Low-voltage programming bit enables that entry path
// [R03] Stack error reset bit makes stack events reset
// [R04] Unimplemented bits always read as zero
// [R05] Block three protected while its bit is zero
// [R06] Block two protected while its bit is zero
// [R07] Block one protected while its bit is zero
// [R08] Data EEPROM protected while its bit is zero
// [R09] Boot region protected while its bit is zero
// [R10] Small variants keep block two, three bits set; here those bits are unimplemented and read zero
// [R11] Blank bits read one; protection bits clear-only
// [R12] Block zero protected while its bit is zero
`timescale 1ns/10ps
`default_nettype none
module fuse_protect_bank
#(
    parameter bit SMALL_MEM = 1'b0
)
(
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    input  wire logic [fuse_bank_pkg::ADDR_W-1:0]      awaddr,
    input  wire logic                                  awvalid,
    output logic                                       awready,
    input  wire logic [31:0]                           wdata,
    input  wire logic [3:0]                            wstrb,
    input  wire logic                                  wvalid,
    output logic                                       wready,
    output logic [1:0]                                 bresp,
    output logic                                       bvalid,
    input  wire logic                                  bready,
    input  wire logic [fuse_bank_pkg::ADDR_W-1:0]      araddr,
    input  wire logic                                  arvalid,
    output logic                                       arready,
    output logic [31:0]                                rdata,
    output logic [1:0]                                 rresp,
    output logic                                       rvalid,
    input  wire logic                                  rready,
    input  wire logic                                  stack_full,
    input  wire logic                                  stack_underflow,
    input  wire logic [fuse_bank_pkg::PROG_ADDR_W-1:0] prog_addr,
    output logic                                       stack_reset_req_r,
    output logic                                       debug_pin_a_reserved_r,
    output logic                                       debug_pin_b_reserved_r,
    output logic                                       lowvolt_prog_en_r,
    output logic [fuse_bank_pkg::NUM_BLOCKS-1:0]       prog_block_protect_r,
    output logic                                       eeprom_protect_r,
    output logic                                       boot_region_protect_r,
    output logic                                       prog_addr_protected_r
);

    // ************************************************************
    // Byte layout
    // ************************************************************
    localparam logic [7:0] PROG_MASK = SMALL_MEM ? fuse_bank_pkg::SMALL_IMPL
                                                 : fuse_bank_pkg::PROG_IMPL;
    localparam logic [2:0][7:0] IMPL_TBL  = {fuse_bank_pkg::BOOT_IMPL, PROG_MASK,
                                             fuse_bank_pkg::DEBUG_IMPL};
    localparam logic [2:0][7:0] CLEAR_TBL = {fuse_bank_pkg::BOOT_CLR,
                                             fuse_bank_pkg::PROG_CLR & PROG_MASK,
                                             fuse_bank_pkg::DEBUG_CLR};

    if (fuse_bank_pkg::NUM_REGS != 3)
    begin : g_bad_regs
        $error("Fuse bank is laid out for three bytes");
    end

    // One-hot select of the addressed byte; zero when unmapped
    function automatic logic [2:0] reg_sel(input logic [fuse_bank_pkg::ADDR_W-1:0] addr);
        reg_sel = {addr == fuse_bank_pkg::BOOT_ADDR,
                   addr == fuse_bank_pkg::PROG_ADDR,
                   addr == fuse_bank_pkg::DEBUG_ADDR};
    endfunction

    // Region of a program address: one-hot boot region or block bit
    function automatic logic [4:0] region_of(input logic [20:0] addr);
        logic [7:0] blk;
        blk       = 8'(addr >> fuse_bank_pkg::BLOCK_SHIFT);
        region_of = 5'h00;
        if (addr <= fuse_bank_pkg::BOOT_LAST)
            region_of = 5'h10;
        else if (blk < 8'(fuse_bank_pkg::NUM_BLOCKS))
            region_of = 5'(4'h1 << blk[1:0]);
    endfunction

    // ************************************************************
    // Bus port
    // ************************************************************
    logic                             wr_fire;
    logic [fuse_bank_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0]                      wr_data;
    logic [3:0]                       wr_strb;
    logic                             rd_fire;
    logic [2:0][7:0]                  fuse_val;

    wire logic [2:0]  wr_sel  = reg_sel(wr_addr);
    wire logic [2:0]  rd_sel  = reg_sel(araddr);
    wire logic        wr_ok   = |wr_sel;
    wire logic        rd_ok   = |rd_sel;
    // Byte lane zero carries the whole register
    wire logic [2:0]  wr_hit  = wr_sel & {3{wr_fire & wr_strb[0]}};
    wire logic [7:0]  rd_byte = ({8{rd_sel[0]}} & fuse_val[0])
                              | ({8{rd_sel[1]}} & fuse_val[1])
                              | ({8{rd_sel[2]}} & fuse_val[2]);
    wire logic [31:0] rd_data = {24'h00_0000, rd_byte};

    fuse_axil_port u_port
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_fire (wr_fire),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_fire (rd_fire),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // ************************************************************
    // Fuse bytes
    // ************************************************************
    // Unimplemented bits hold zero and read as zero
    for (genvar g = 0; g < 3; g++)
    begin : g_fuse
        fuse_byte
        #(
            .IMPL_MASK  (IMPL_TBL[g]),
            .CLEAR_MASK (CLEAR_TBL[g])
        )
        u_byte
        (
            .aclk    (aclk),
            .aresetn (aresetn),
            .wr_en   (wr_hit[g]), // R11
            .wr_data (wr_data[7:0]),
            .value_r (fuse_val[g]) // R04
        );
    end

    // ************************************************************
    // Active configuration
    // ************************************************************
    // Fuse changes only act after a device reset, as on silicon
    logic            load_pend_r;
    logic [2:0][7:0] cfg_r;

    wire logic stack_event = stack_full | stack_underflow;
    wire logic stack_rst   = stack_event & cfg_r[fuse_bank_pkg::SLOT_DEBUG][fuse_bank_pkg::STACK_RST_BIT];
    wire logic [7:0] prog_cfg = cfg_r[fuse_bank_pkg::SLOT_PROG];
    wire logic [7:0] boot_cfg = cfg_r[fuse_bank_pkg::SLOT_BOOT];
    wire logic [4:0] region   = region_of(prog_addr);
    wire logic [4:0] prot_vec = {~boot_cfg[fuse_bank_pkg::BOOT_BIT], ~prog_cfg[3:0]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            load_pend_r <= 1'b1;
            cfg_r       <= '0;
        end
        else
        begin
            load_pend_r <= stack_rst; // R03
            if (load_pend_r)
                cfg_r <= fuse_val;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stack_reset_req_r      <= 1'b0;
            debug_pin_a_reserved_r <= 1'b0;
            debug_pin_b_reserved_r <= 1'b0;
            lowvolt_prog_en_r      <= 1'b0;
            prog_block_protect_r   <= '0;
            eeprom_protect_r       <= 1'b0;
            boot_region_protect_r  <= 1'b0;
            prog_addr_protected_r  <= 1'b0;
        end
        else
        begin
            stack_reset_req_r      <= stack_rst; // R03
            debug_pin_a_reserved_r <= ~cfg_r[0][fuse_bank_pkg::DBG_OFF_BIT]; // R01
            debug_pin_b_reserved_r <= ~cfg_r[0][fuse_bank_pkg::DBG_OFF_BIT]; // R01
            lowvolt_prog_en_r      <= cfg_r[0][fuse_bank_pkg::LOWVOLT_BIT]; // R02
            // Missing blocks on small parts are never reported protected
            prog_block_protect_r   <= ~prog_cfg[3:0] & PROG_MASK[3:0]; // R05 R06 R07 R12 R10
            eeprom_protect_r       <= ~boot_cfg[fuse_bank_pkg::EEPROM_BIT]; // R08
            boot_region_protect_r  <= ~boot_cfg[fuse_bank_pkg::BOOT_BIT]; // R09
            prog_addr_protected_r  <= |(region & prot_vec & {1'b1, PROG_MASK[3:0]});
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Sampled reset in the antecedents keeps the reset edge itself out
    a_debug_pins_owner: assert property ( // R01
        load_pend_r && aresetn |=> ##1 debug_pin_a_reserved_r == debug_pin_b_reserved_r
            && debug_pin_a_reserved_r == !$past(fuse_val[0][7], 2))
        else $error("Debug pin ownership does not follow the fuse");
    a_lowvolt_follow: assert property ( // R02
        load_pend_r && aresetn |=> ##1 lowvolt_prog_en_r == $past(fuse_val[0][2], 2))
        else $error("Low-voltage programming enable does not follow the fuse");
    a_stack_reset_on: assert property ( // R03
        stack_event && cfg_r[0][0] |=> stack_reset_req_r ##1 cfg_r == $past(fuse_val))
        else $error("Stack event did not reset and reload");
    a_stack_reset_off: assert property ( // R03
        !(stack_event && cfg_r[0][0]) |=> !stack_reset_req_r)
        else $error("Stack reset raised while disabled");
    a_unimpl_zero: assert property ( // R04
        rvalid |-> rdata[31:8] == 24'h00_0000 && (fuse_val[0] & ~8'h85) == 8'h00
            && (fuse_val[2] & ~8'hC0) == 8'h00)
        else $error("Unimplemented bit reads nonzero");
    a_block_protect: assert property ( // R05 R06 R07 R12
        aresetn && $stable(prog_cfg) |=> prog_block_protect_r == (~$past(prog_cfg[3:0]) & PROG_MASK[3:0]))
        else $error("Block protection does not follow its bit");
    a_boot_eeprom: assert property ( // R08 R09
        aresetn && $stable(boot_cfg) |=> {eeprom_protect_r, boot_region_protect_r} == ~$past(boot_cfg[7:6]))
        else $error("Boot or EEPROM protection does not follow its bit");
    a_small_variant: assert property ( // R10
        SMALL_MEM |-> prog_block_protect_r[3:2] == 2'b00 && fuse_val[1][3:2] == 2'b00)
        else $error("Small variant reports upper blocks");
    a_clear_only: assert property ( // R11
        1'b1 |=> ((fuse_val[1] | fuse_val[2]) & ~($past(fuse_val[1]) | $past(fuse_val[2]))) == 8'h00)
        else $error("Protection bit was set again");
    a_blank_ones: assert property ( // R11
        $rose(aresetn) |-> fuse_val == {fuse_bank_pkg::BOOT_IMPL, PROG_MASK,
                                        fuse_bank_pkg::DEBUG_IMPL})
        else $error("Blank fuses are not all ones");
    a_unmapped_err: assert property (
        rd_fire && !rd_ok |=> rvalid && rresp == fuse_bank_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("Unmapped read not refused");

    c_write_prog: cover property (wr_hit[1] ##1 bvalid && bresp == fuse_bank_pkg::RESP_OKAY);
    c_stack_reset: cover property (stack_reset_req_r ##2 prog_block_protect_r != 4'h0);
    c_debug_on: cover property (debug_pin_a_reserved_r);
    c_read_boot: cover property (rd_fire && rd_sel[2]);

endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the configuration fuse bank.
// Assumes AXI4-Lite register access and a reload on stack reset.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                               aclk = 1'b0;
    logic                               aresetn = 1'b0;
    logic [fuse_bank_pkg::ADDR_W-1:0]   awaddr = '0;
    logic [fuse_bank_pkg::ADDR_W-1:0]   araddr = '0;
    logic [31:0]                        wdata = '0;
    logic [3:0]                         wstrb = '0;
    logic                               awvalid = 1'b0;
    logic                               wvalid = 1'b0;
    logic                               bready = 1'b0;
    logic                               arvalid = 1'b0;
    logic                               rready = 1'b0;
    logic                               stack_full = 1'b0;
    logic                               stack_underflow = 1'b0;
    logic [20:0]                        prog_addr = '0;
    logic                               awready, wready, bvalid, arready, rvalid;
    logic [1:0]                         bresp, rresp;
    logic [31:0]                        rdata;
    logic                               req, pin_a, pin_b, lowvolt, eeprom, boot, hit;
    logic [3:0]                         blocks;
    int                                 n_errors = 0;
    int                                 cmp_count = 0;
    int                                 cycles = 0;

    fuse_protect_bank dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .stack_full(stack_full), .stack_underflow(stack_underflow),
        .prog_addr(prog_addr), .stack_reset_req_r(req), .debug_pin_a_reserved_r(pin_a),
        .debug_pin_b_reserved_r(pin_b), .lowvolt_prog_en_r(lowvolt),
        .prog_block_protect_r(blocks), .eeprom_protect_r(eeprom),
        .boot_region_protect_r(boot), .prog_addr_protected_r(hit));

    always #5 aclk = ~aclk;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ************************************************************
    // Bus tasks
    // ************************************************************
    // Handshakes are sampled at the falling edge, where inputs equal the next rising edge
    task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] rsp);
        logic ah, wh, bh;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        while (!bh)
        begin
            @(negedge aclk);
            ah = awready;
            wh = wready;
            bh = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ah)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rchk(input logic [23:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        while (!rh)
        begin
            @(negedge aclk);
            ah = arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk("rdata", e, d);
        chk("rresp", 32'(er), 32'(r));
    endtask

    // One-cycle stack event, then the request is looked at in the next cycle
    task automatic stack_evt(input logic full, input logic exp_req);
        @(posedge aclk);
        stack_full <= full;
        stack_underflow <= !full;
        @(posedge aclk);
        stack_full <= 1'b0;
        stack_underflow <= 1'b0;
        #1;
        chk("stack_reset_req", 32'(exp_req), 32'(req));
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_blank;
        rchk(fuse_bank_pkg::DEBUG_ADDR, 32'h0000_0085, 2'h0);
        rchk(fuse_bank_pkg::PROG_ADDR, 32'h0000_000F, 2'h0);
        rchk(fuse_bank_pkg::BOOT_ADDR, 32'h0000_00C0, 2'h0);
        chk("pins", 32'h0000_0000, {pin_a, pin_b});
        chk("lowvolt", 32'h0000_0001, lowvolt);
        chk("protect", 32'h0000_0000, {blocks, eeprom, boot});
        stack_evt(1'b0, 1'b1);
    endtask

    task automatic t_program;
        logic [1:0] r;
        wr(24'hC0_0010, 8'h00, 4'h1, r);
        chk("bresp unmapped", 32'h0000_0002, r);
        rchk(24'hC0_0010, 32'h0000_0000, 2'h2);
        wr(fuse_bank_pkg::DEBUG_ADDR, 8'h00, 4'h2, r);
        rchk(fuse_bank_pkg::DEBUG_ADDR, 32'h0000_0085, 2'h0);
        wr(fuse_bank_pkg::DEBUG_ADDR, 8'hFF, 4'h1, r);
        rchk(fuse_bank_pkg::DEBUG_ADDR, 32'h0000_0085, 2'h0);
        wr(fuse_bank_pkg::DEBUG_ADDR, 8'h00, 4'h1, r);
        rchk(fuse_bank_pkg::DEBUG_ADDR, 32'h0000_0000, 2'h0);
        wr(fuse_bank_pkg::PROG_ADDR, 8'hFA, 4'h1, r);
        rchk(fuse_bank_pkg::PROG_ADDR, 32'h0000_000A, 2'h0);
        wr(fuse_bank_pkg::PROG_ADDR, 8'hFF, 4'h1, r);
        chk("bresp okay", 32'h0000_0000, r);
        rchk(fuse_bank_pkg::PROG_ADDR, 32'h0000_000A, 2'h0);
        wr(fuse_bank_pkg::BOOT_ADDR, 8'h7F, 4'h1, r);
        rchk(fuse_bank_pkg::BOOT_ADDR, 32'h0000_0040, 2'h0);
    endtask

    task automatic t_reload;
        logic [20:0] pa [6] = '{21'h00_6000, 21'h00_4000, 21'h00_2000,
                                21'h00_0300, 21'h00_0100, 21'h00_8000};
        logic        ph [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        stack_evt(1'b1, 1'b1);
        chk("pins", 32'h0000_0003, {pin_a, pin_b});
        chk("lowvolt", 32'h0000_0000, lowvolt);
        chk("blocks", 32'h0000_0005, blocks);
        chk("eeprom", 32'h0000_0001, eeprom);
        chk("boot", 32'h0000_0000, boot);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge aclk);
            prog_addr <= pa[i];
            repeat (2) @(posedge aclk);
            #1;
            chk("addr_protected", 32'(ph[i]), hit);
        end
        // Stack reset bit now cleared, so no request may follow
        stack_evt(1'b1, 1'b0);
    endtask

    task end_of_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_blank();
        t_program();
        t_reload();
        end_of_test();
    end
endmodule
`default_nettype wire
